// [rtl/engine_timing_consts.svh]
// Purpose: Constants for the engine speed and spark timing block.
// Assumes: 100 MHz reference clock.
// Notes: Offsets are byte addresses on the register bus.
`ifndef ENGINE_TIMING_CONSTS_SVH
`define ENGINE_TIMING_CONSTS_SVH
`define CLK_HZ 100000000
`define SAMPLE_PERIOD_MS 20
`define SAMPLE_CYCLES ((`CLK_HZ / 1000) * `SAMPLE_PERIOD_MS)
`define OFS_CONFIG 8'h00
`define OFS_CRANK 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0C
`define OFS_ALARM_SEL 8'h10
`define OFS_ALARM_HI 8'h14
`define OFS_ALARM_LO 8'h18
`define OFS_OXY_LIMIT 8'h1C
`define OFS_SPD_ZERO 8'h20
`define OFS_SPD_FULL 8'h24
`define OFS_SPK_ZERO 8'h28
`define OFS_SPK_FULL 8'h2C
`define OFS_SPEED 8'h30
`define OFS_ANGLE 8'h34
`define OFS_SPD_INTV 8'h38
`define OFS_SPK_INTV 8'h3C
`define OFS_MIXTURE 8'h40
`define OFS_DAC 8'h44
`define RPM_NUM 120
`define DEG_CYCLE 720
`define ANGLE_MIN (-60)
`define ANGLE_MAX 30
`define ANGLE_NONE 31
`define MISS_PERIODS 2
`define SPAN_NARROW 60
`define PPC_WIDE_LIMIT 8
`define MIN_SPAN_RPM 500
`define MIN_SPAN_DEG 20
`define DAC_FULL 12'hFFF
`define CFG_RESET 32'h0000_0404
`define OKAY 2'b00
`define SLVERR 2'b10
`define FAST_DIV 21
`define SLOW_DIV 24
`endif

// [rtl/engine_timing_pkg.sv]
// Purpose: Types for the engine speed and spark timing block.
// Assumes: Constants come from engine_timing_consts.svh.
// Notes: The whole state of the top module is one packed struct.
package engine_timing_pkg;
  typedef struct packed {
    logic spdPrev;
    logic spkPrev;
    logic spkArmed;
    logic [31:0] spdCnt;
    logic [31:0] spkCnt;
    logic [31:0] spkSrcCnt;
    logic [31:0] spdIntv;
    logic [31:0] spkIntv;
    logic [31:0] srcIntv;
    logic [31:0] sampleCnt;
    logic [15:0] speed;
    logic signed [15:0] angle;
    logic spdValid;
    logic [7:0] sparkSeen;
    logic [31:0] cfg;
    logic signed [15:0] crank;
    logic [3:0] status;
    logic [3:0] mask;
    logic [1:0] alarmSel;
    logic signed [15:0] alarmHi;
    logic signed [15:0] alarmLo;
    logic [15:0] oxyLimit;
    logic [15:0] mixture;
    logic [15:0] spdZero;
    logic [15:0] spdFull;
    logic signed [15:0] spkZero;
    logic signed [15:0] spkFull;
    logic [11:0] dacSpeed;
    logic [11:0] dacAngle;
    logic oxySwitch;
    logic alarmHigh;
    logic alarmLow;
    logic [24:0] beepCnt;
    logic buzzer;
    logic irq;
    logic awGot;
    logic wGot;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } timing_state_t;
endpackage : engine_timing_pkg

// [rtl/engine_speed_spark_timing.sv]
// Purpose: Times engine speed and spark edges, derives speed and angle, drives alarms and outputs.
// Assumes: Conditioned pickup inputs synchronous to ref_clk; AXI4-Lite register access.
// Notes: Config bits: 0 speed edge, 1 spark edge, 2 speed from spark, 15:8 speed ppc,
//   23:16 spark ppc. Angle is whole degrees, signed. Status: 0 speed, 1 angle, 2 miss, 3 stall.
//
// Overview of operation
// - Speed interval is the time between two successive active speed edges.
// - Speed in RPM equals 120 over interval seconds times speed pulses per cycle.
// - Spark interval runs from latest speed edge to next spark edge.
// - Only the first spark edge after a speed edge is used.
// - Raw angle is crank angle plus interval ratio times 720 over pulses.
// - Optionally speed is derived from spark edge intervals by the same formula.
// - Spark pulses per cycle detect missing spark pulses.
// - Reported angle is corrected and held within -60 to 30 degrees at 8 or fewer speed pulses per cycle.
// - Above 8 speed pulses per cycle the span is 60 degrees from a start angle.
// - High alarm, red lamp, fast buzzer while selected value exceeds its threshold.
// - Low alarm, green lamp, slow buzzer unless high alarm is on, while selected value is below threshold.
// - Oxygen switch high when richer than transition, low when leaner, every 20 ms.
// - Analog outputs are 12-bit linear codes over their span, updated every 20 ms.
// - Analog spans below 500 RPM or 20 degrees are rejected.
// - Speed and spark active edge polarity are separately selectable.
// - Speed and angle are held between edge updates; analog and oxygen outputs are sampled every 20 ms.
// - Missing spark or out-of-range angle reports 31.
`timescale 1ns/1ps
`include "engine_timing_consts.svh"
module engine_speed_spark_timing
  import engine_timing_pkg::*;
#(
  parameter int SAMPLE_TICKS = `SAMPLE_CYCLES
) (
  input wire logic ref_clk, // Reference clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic speedPulse, // Conditioned speed pickup.
  input wire logic sparkPulse, // Conditioned spark pickup.
  input wire logic [15:0] mixtureIn, // Measured mixture ratio, larger is leaner.
  input wire logic awvalid, // AXI write address valid.
  output logic awready, // AXI write address ready.
  input wire logic [7:0] awaddr, // AXI write address.
  input wire logic [2:0] awprot, // AXI protection, unused.
  input wire logic wvalid, // AXI write data valid.
  output logic wready, // AXI write data ready.
  input wire logic [31:0] wdata, // AXI write data.
  input wire logic [3:0] wstrb, // AXI byte strobes.
  output logic bvalid, // AXI write response valid.
  input wire logic bready, // AXI write response ready.
  output logic [1:0] bresp, // AXI write response.
  input wire logic arvalid, // AXI read address valid.
  output logic arready, // AXI read address ready.
  input wire logic [7:0] araddr, // AXI read address.
  input wire logic [2:0] arprot, // AXI protection, unused.
  output logic rvalid, // AXI read data valid.
  input wire logic rready, // AXI read data ready.
  output logic [31:0] rdata, // AXI read data.
  output logic [1:0] rresp, // AXI read response.
  output logic [11:0] dacSpeed, // Speed analog code.
  output logic [11:0] dacAngle, // Spark angle analog code.
  output logic simulated_oxygen_switch, // Simulated oxygen switch.
  output logic alarmHigh, // Red lamp.
  output logic alarmLow, // Green lamp.
  output logic buzzer, // Buzzer drive.
  output logic irq // Interrupt, level.
);

  timing_state_t cur_ff, nxt_ff;

  // Speed polarity is bit 0, spark bit 1: 0 rising, 1 falling.
  function automatic logic edgeSeen(input logic prev, input logic now, input logic fall);
    edgeSeen = fall ? (prev & ~now) : (~prev & now);
  endfunction : edgeSeen

  function automatic logic [15:0] rpmOf(input logic [31:0] ticks, input logic [7:0] ppc);
    logic [63:0] den;
    den = 64'(ticks) * 64'(ppc);
    rpmOf = (den == 64'h0) ? 16'h0000 :
            16'((64'(`RPM_NUM) * 64'(`CLK_HZ)) / den);
  endfunction : rpmOf

  function automatic logic [11:0] scale12(input logic signed [31:0] v,
                                         input logic signed [31:0] lo,
                                         input logic signed [31:0] hi);
    logic signed [47:0] t;
    t = 48'sd0;
    if (v <= lo) begin
      scale12 = 12'h000;
    end else if (v >= hi) begin
      scale12 = `DAC_FULL;
    end else begin
      t = (48'(v - lo) * 48'(`DAC_FULL)) / 48'(hi - lo);
      scale12 = t[11:0];
    end
  endfunction : scale12

  assign dacSpeed = cur_ff.dacSpeed;
  assign dacAngle = cur_ff.dacAngle;
  assign simulated_oxygen_switch = cur_ff.oxySwitch;
  assign alarmHigh = cur_ff.alarmHigh;
  assign alarmLow = cur_ff.alarmLow;
  assign buzzer = cur_ff.buzzer;
  assign irq = cur_ff.irq;
  assign awready = ~cur_ff.awGot & ~cur_ff.bValid;
  assign wready = ~cur_ff.wGot & ~cur_ff.bValid;
  assign bvalid = cur_ff.bValid;
  assign bresp = cur_ff.bResp;
  assign arready = ~cur_ff.rValid;
  assign rvalid = cur_ff.rValid;
  assign rdata = cur_ff.rData;
  assign rresp = cur_ff.rResp;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic spdEdge, spkEdge, sampleTick, wrNow, rdNow;
    logic [7:0] spdPpc, spkPpc, wa;
    logic [3:0] events;
    logic signed [63:0] rawAngle;
    logic signed [31:0] angleLo, angleHi, sel;
    logic [31:0] wd;
    spdEdge = 1'b0;
    spkEdge = 1'b0;
    sampleTick = 1'b0;
    wrNow = 1'b0;
    rdNow = 1'b0;
    spdPpc = 8'h00;
    spkPpc = 8'h00;
    wa = 8'h00;
    events = 4'h0;
    rawAngle = 64'sd0;
    angleLo = 32'sd0;
    angleHi = 32'sd0;
    sel = 32'sd0;
    wd = 32'h0;
    nxt_ff = cur_ff;
    spdPpc = cur_ff.cfg[15:8];
    spkPpc = cur_ff.cfg[23:16];
    nxt_ff.spdPrev = speedPulse;
    nxt_ff.spkPrev = sparkPulse;
    spdEdge = edgeSeen(cur_ff.spdPrev, speedPulse, cur_ff.cfg[0]);
    spkEdge = edgeSeen(cur_ff.spkPrev, sparkPulse, cur_ff.cfg[1]);
    // Counters saturate instead of wrapping so a stalled engine never aliases a fast one.
    if (cur_ff.spdCnt != 32'hFFFF_FFFF) nxt_ff.spdCnt = cur_ff.spdCnt + 32'h1;
    if (cur_ff.spkCnt != 32'hFFFF_FFFF) nxt_ff.spkCnt = cur_ff.spkCnt + 32'h1;
    if (cur_ff.spkSrcCnt != 32'hFFFF_FFFF) nxt_ff.spkSrcCnt = cur_ff.spkSrcCnt + 32'h1;
    if (cur_ff.spdCnt == 32'hFFFF_FFFE) begin
      nxt_ff.spdValid = 1'b0;
      events[3] = 1'b1;
    end
    if (spdEdge) begin
      nxt_ff.spdIntv = cur_ff.spdCnt + 32'h1;
      nxt_ff.spdCnt = 32'h0;
      nxt_ff.spkCnt = 32'h0;
      nxt_ff.spkArmed = 1'b1;
      nxt_ff.spdValid = 1'b1;
      // Speed edges since the last spark; two whole spark periods without one is a miss.
      if (cur_ff.sparkSeen != 8'hFF) nxt_ff.sparkSeen = cur_ff.sparkSeen + 8'h01;
      if (spkPpc != 8'h00 && spdPpc != 8'h00 &&
          16'(cur_ff.sparkSeen) * 16'(spkPpc) >= 16'(`MISS_PERIODS) * 16'(spdPpc)) begin
        events[2] = 1'b1;
        nxt_ff.angle = 16'(`ANGLE_NONE);
      end
      if (!cur_ff.cfg[2]) begin
        nxt_ff.speed = rpmOf(cur_ff.spdCnt + 32'h1, spdPpc);
        events[0] = 1'b1;
      end
    end
    if (spkEdge) begin
      nxt_ff.srcIntv = cur_ff.spkSrcCnt + 32'h1;
      nxt_ff.spkSrcCnt = 32'h0;
      nxt_ff.sparkSeen = 8'h00;
      if (cur_ff.cfg[2]) begin
        nxt_ff.speed = rpmOf(cur_ff.spkSrcCnt + 32'h1, spkPpc);
        events[0] = 1'b1;
      end
    end
    if (spkEdge && cur_ff.spkArmed && !spdEdge) begin
      nxt_ff.spkArmed = 1'b0;
      nxt_ff.spkIntv = cur_ff.spkCnt + 32'h1;
      if (cur_ff.spdValid && spdPpc != 8'h00 && cur_ff.spdIntv != 32'h0) begin
        rawAngle = 64'(cur_ff.crank) + (64'(cur_ff.spkCnt + 32'h1) * 64'(`DEG_CYCLE)) /
                   (64'(cur_ff.spdIntv) * 64'(spdPpc));
        // Fold onto a 720 degree cycle centred on top dead centre when the raw angle is not negative.
        rawAngle = rawAngle % 64'(`DEG_CYCLE);
        if (rawAngle > 64'sd360) rawAngle = rawAngle - 64'(`DEG_CYCLE);
        if (spdPpc > 8'(`PPC_WIDE_LIMIT)) begin
          angleLo = 32'(cur_ff.cfg[31:24]) - 32'sd128;
          angleHi = angleLo + 32'(`SPAN_NARROW);
        end else begin
          angleLo = 32'(`ANGLE_MIN);
          angleHi = 32'(`ANGLE_MAX);
        end
        if (rawAngle < 64'(angleLo) || rawAngle > 64'(angleHi)) begin
          nxt_ff.angle = 16'(`ANGLE_NONE);
        end else begin
          nxt_ff.angle = 16'(rawAngle);
        end
      end else begin
        nxt_ff.angle = 16'(`ANGLE_NONE);
      end
      events[1] = 1'b1;
    end
    // Analog and oxygen switch outputs refresh only on the sample tick so they step every 20 ms.
    if (cur_ff.sampleCnt >= 32'(SAMPLE_TICKS - 1)) begin
      nxt_ff.sampleCnt = 32'h0;
      sampleTick = 1'b1;
    end else begin
      nxt_ff.sampleCnt = cur_ff.sampleCnt + 32'h1;
    end
    if (sampleTick) begin
      nxt_ff.mixture = mixtureIn;
      nxt_ff.oxySwitch = (mixtureIn < cur_ff.oxyLimit);
      nxt_ff.dacSpeed = scale12(32'(cur_ff.speed), 32'(cur_ff.spdZero),
                                32'(cur_ff.spdFull));
      nxt_ff.dacAngle = scale12(32'(cur_ff.angle), 32'(cur_ff.spkZero),
                                32'(cur_ff.spkFull));
    end
    case (cur_ff.alarmSel)
      2'd0: sel = 32'(cur_ff.speed);
      2'd1: sel = 32'(cur_ff.angle);
      2'd2: sel = 32'(cur_ff.mixture);
      default: sel = 32'sd0;
    endcase
    nxt_ff.alarmHigh = sel > 32'(cur_ff.alarmHi);
    nxt_ff.alarmLow = sel < 32'(cur_ff.alarmLo);
    nxt_ff.beepCnt = cur_ff.beepCnt + 25'h1;
    nxt_ff.buzzer = (cur_ff.alarmHigh & cur_ff.beepCnt[`FAST_DIV]) |
                    (cur_ff.alarmLow & ~cur_ff.alarmHigh & cur_ff.beepCnt[`SLOW_DIV]);
    // Register bus: one write and one read at a time.
    if (awvalid && awready) begin
      nxt_ff.awGot = 1'b1;
      nxt_ff.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_ff.wGot = 1'b1;
      nxt_ff.wData = wdata;
    end
    wrNow = nxt_ff.awGot & nxt_ff.wGot & ~cur_ff.bValid;
    wa = nxt_ff.awAddr;
    wd = nxt_ff.wData;
    if (wrNow) begin
      nxt_ff.awGot = 1'b0;
      nxt_ff.wGot = 1'b0;
      nxt_ff.bValid = 1'b1;
      nxt_ff.bResp = `OKAY;
      case (wa)
        `OFS_CONFIG: nxt_ff.cfg = wd;
        `OFS_CRANK: nxt_ff.crank = wd[15:0];
        `OFS_STATUS: nxt_ff.status = cur_ff.status & ~wd[3:0];
        `OFS_MASK: nxt_ff.mask = wd[3:0];
        `OFS_ALARM_SEL: nxt_ff.alarmSel = wd[1:0];
        `OFS_ALARM_HI: nxt_ff.alarmHi = wd[15:0];
        `OFS_ALARM_LO: nxt_ff.alarmLo = wd[15:0];
        `OFS_OXY_LIMIT: nxt_ff.oxyLimit = wd[15:0];
        `OFS_SPD_ZERO, `OFS_SPD_FULL: begin
          if (wa == `OFS_SPD_ZERO) nxt_ff.spdZero = wd[15:0];
          else nxt_ff.spdFull = wd[15:0];
          // A span narrower than the minimum keeps the old pair.
          if (nxt_ff.spdFull < nxt_ff.spdZero ||
              32'(nxt_ff.spdFull) - 32'(nxt_ff.spdZero) < 32'(`MIN_SPAN_RPM)) begin
            nxt_ff.spdZero = cur_ff.spdZero;
            nxt_ff.spdFull = cur_ff.spdFull;
            nxt_ff.bResp = `SLVERR;
          end
        end
        `OFS_SPK_ZERO, `OFS_SPK_FULL: begin
          if (wa == `OFS_SPK_ZERO) nxt_ff.spkZero = wd[15:0];
          else nxt_ff.spkFull = wd[15:0];
          if (32'(nxt_ff.spkFull) - 32'(nxt_ff.spkZero) < 32'(`MIN_SPAN_DEG)) begin
            nxt_ff.spkZero = cur_ff.spkZero;
            nxt_ff.spkFull = cur_ff.spkFull;
            nxt_ff.bResp = `SLVERR;
          end
        end
        default: nxt_ff.bResp = `SLVERR;
      endcase
    end
    if (cur_ff.bValid && bready) nxt_ff.bValid = 1'b0;
    rdNow = arvalid & ~cur_ff.rValid;
    if (rdNow) begin
      nxt_ff.rValid = 1'b1;
      nxt_ff.rResp = `OKAY;
      case (araddr)
        `OFS_CONFIG: nxt_ff.rData = cur_ff.cfg;
        `OFS_CRANK: nxt_ff.rData = 32'(cur_ff.crank);
        `OFS_STATUS: nxt_ff.rData = {28'h0, cur_ff.status};
        `OFS_MASK: nxt_ff.rData = {28'h0, cur_ff.mask};
        `OFS_ALARM_SEL: nxt_ff.rData = {30'h0, cur_ff.alarmSel};
        `OFS_ALARM_HI: nxt_ff.rData = 32'(cur_ff.alarmHi);
        `OFS_ALARM_LO: nxt_ff.rData = 32'(cur_ff.alarmLo);
        `OFS_OXY_LIMIT: nxt_ff.rData = {16'h0, cur_ff.oxyLimit};
        `OFS_SPD_ZERO: nxt_ff.rData = {16'h0, cur_ff.spdZero};
        `OFS_SPD_FULL: nxt_ff.rData = {16'h0, cur_ff.spdFull};
        `OFS_SPK_ZERO: nxt_ff.rData = 32'(cur_ff.spkZero);
        `OFS_SPK_FULL: nxt_ff.rData = 32'(cur_ff.spkFull);
        `OFS_SPEED: nxt_ff.rData = {15'h0, cur_ff.spdValid, cur_ff.speed};
        `OFS_ANGLE: nxt_ff.rData = 32'(cur_ff.angle);
        `OFS_SPD_INTV: nxt_ff.rData = cur_ff.spdIntv;
        `OFS_SPK_INTV: nxt_ff.rData = cur_ff.spkIntv;
        `OFS_MIXTURE: nxt_ff.rData = {16'h0, cur_ff.mixture};
        `OFS_DAC: nxt_ff.rData = {4'h0, cur_ff.dacAngle, 4'h0, cur_ff.dacSpeed};
        default: begin
          nxt_ff.rData = 32'h0;
          nxt_ff.rResp = `SLVERR;
        end
      endcase
    end else if (cur_ff.rValid && rready) begin
      nxt_ff.rValid = 1'b0;
    end
    // Set wins over a same-cycle write-one-to-clear.
    nxt_ff.status = nxt_ff.status | events;
    nxt_ff.irq = |(nxt_ff.status & nxt_ff.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cur_ff <= '0;
      cur_ff.cfg <= `CFG_RESET;
      cur_ff.spdFull <= 16'(`MIN_SPAN_RPM);
      cur_ff.spkZero <= 16'(`ANGLE_MIN);
      cur_ff.spkFull <= 16'(`ANGLE_MAX);
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_speed_interval: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (edgeSeen(cur_ff.spdPrev, speedPulse, cur_ff.cfg[0]) && cur_ff.spdCnt < 32'hFFFF_FFFE)
    |=> (cur_ff.spdIntv == $past(cur_ff.spdCnt) + 32'h1 && cur_ff.spdCnt == 32'h0))
    else $error("speed interval not captured");
  a_first_spark: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!cur_ff.spkArmed && !edgeSeen(cur_ff.spdPrev, speedPulse, cur_ff.cfg[0]))
    |=> (cur_ff.spkIntv == $past(cur_ff.spkIntv)))
    else $error("later spark edge was used");
  a_angle_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur_ff.cfg[15:8] <= 8'(`PPC_WIDE_LIMIT)) |-> ((cur_ff.angle == 16'(`ANGLE_NONE)) ||
    ($signed(cur_ff.angle) >= 16'sd0 - 16'sd60 && $signed(cur_ff.angle) <= 16'sd30)))
    else $error("spark angle out of span");
  a_alarm_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur_ff.alarmSel == 2'd0 && cur_ff.speed > cur_ff.alarmHi[15:0] && !cur_ff.alarmHi[15]
    && $stable(cur_ff.speed) && $stable(cur_ff.alarmHi) && $stable(cur_ff.alarmSel))
    |=> alarmHigh)
    else $error("high alarm missing");
  a_alarm_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur_ff.alarmSel == 2'd2 && !cur_ff.alarmLo[15])
    |=> (alarmLow == ($past(cur_ff.mixture) < $past(cur_ff.alarmLo[15:0]))))
    else $error("low alarm wrong");
  a_sample_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur_ff.sampleCnt != 32'h0) |-> $stable(dacSpeed) && $stable(simulated_oxygen_switch))
    else $error("outputs changed between samples");
  a_span_min: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (32'(cur_ff.spdFull) - 32'(cur_ff.spdZero) >= 32'(`MIN_SPAN_RPM)))
    else $error("speed span below minimum");
  a_stall_invalid: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur_ff.spdCnt == 32'hFFFF_FFFF) |-> !cur_ff.spdValid)
    else $error("stalled speed still valid");

endmodule : engine_speed_spark_timing

// [bench/pickup_pulse_model.sv]
// Purpose: Conditioned speed and spark pickup pulse trains for the timing bench.
// Assumes: Bench changes the controls just after a rising clock edge.
// Notes: An optional second spark pulse follows the first within each speed period.
`timescale 1ns/1ps
module pickup_pulse_model #(
  parameter int WIDTH = 20
) (
  input wire logic ref_clk, // Reference clock.
  input wire logic run, // Pulse trains enabled.
  input wire logic sparkOn, // Spark pulses enabled.
  input wire logic extra, // Second spark pulse enabled.
  input wire logic [15:0] period, // Speed edge spacing in cycles.
  input wire logic [15:0] delay, // Spark edge after speed edge.
  output logic speedPulse, // Conditioned speed pickup.
  output logic sparkPulse // Conditioned spark pickup.
);
  logic [15:0] cntFf;
  logic [15:0] ofs;
  logic [15:0] ofs2;
  //////////////////////////////////////////////////////////////////////////////
  assign ofs = cntFf - delay;
  assign ofs2 = ofs - 16'(2 * WIDTH);
  // Both lines rest low while stopped, so a halt never looks like a rising edge.
  always_ff @(posedge ref_clk) begin
    if (!run || cntFf >= period - 16'h1) begin
      cntFf <= 16'h0;
    end else begin
      cntFf <= cntFf + 16'h1;
    end
    speedPulse <= run && cntFf < 16'(WIDTH);
    sparkPulse <= run && sparkOn && (ofs < 16'(WIDTH) || (extra && ofs2 < 16'(WIDTH)));
  end
endmodule : pickup_pulse_model

// [bench/tb_engine_speed_spark_timing.sv]
// Purpose: Self-checking bench for the engine speed and spark timing block.
// Assumes: Sample tick shortened to 50 cycles; pickups from pickup_pulse_model.
// Notes: Expected results queue up; a monitor compares each answer as it appears.
`timescale 1ns/1ps
`include "engine_timing_consts.svh"
module tb_engine_speed_spark_timing;
  localparam int ST = 50;
  localparam int P = 1000;
  localparam int D = 250;
  localparam int W = 20;
  localparam logic [33:0] ALL = {34{1'b1}};
  localparam logic [33:0] LOW16 = 34'h3_0000_FFFF;
  localparam logic [31:0] SPD = 32'h1_0000 | 32'(longint'(`RPM_NUM) * `CLK_HZ / (P * 255));
  typedef struct {string name; logic [33:0] exp; logic [33:0] msk;} note_t;
  note_t notes[$];
  logic ref_clk, reset_n, speedPulse, sparkPulse, run, sparkOn, extra, probeReq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] mixtureIn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [11:0] dacSpeed, dacAngle;
  logic oxySwitch, alarmHigh, alarmLow, irq;
  int miscompares, cmpCount, cycles;
  //////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  engine_speed_spark_timing #(.SAMPLE_TICKS(ST)) u_engine_speed_spark_timing (
    .ref_clk(ref_clk), .reset_n(reset_n), .speedPulse(speedPulse), .sparkPulse(sparkPulse),
    .mixtureIn(mixtureIn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .dacSpeed(dacSpeed), .dacAngle(dacAngle),
    .simulated_oxygen_switch(oxySwitch), .alarmHigh(alarmHigh), .alarmLow(alarmLow),
    .buzzer(), .irq(irq));
  pickup_pulse_model #(.WIDTH(W)) u_pickup_pulse_model (
    .ref_clk(ref_clk), .run(run), .sparkOn(sparkOn), .extra(extra), .period(16'(P)),
    .delay(16'(D)), .speedPulse(speedPulse), .sparkPulse(sparkPulse));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic compare(input logic [33:0] seen);
    note_t n;
    n = notes.pop_front();
    cmpCount++;
    if ((seen & n.msk) !== (n.exp & n.msk)) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", n.name, n.exp & n.msk, seen & n.msk);
    end
  endtask : compare
  // Outputs are looked at mid-cycle, where they have settled; a handshake seen there
  // completes at the next rising edge, so each answer is compared exactly once.
  always @(negedge ref_clk) begin
    cycles++;
    if (rvalid && rready) compare({rresp, rdata});
    if (bvalid && bready) compare({bresp, 32'h0});
    if (probeReq) compare({6'h0, dacAngle, dacSpeed, irq, alarmHigh, alarmLow, oxySwitch});
    if (cycles > 40000) begin
      miscompares++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw;
    bit w;
    bit takeAw;
    bit takeW;
    @(posedge ref_clk);
    notes.push_back('{"bresp", {r, 32'h0}, ALL});
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(negedge ref_clk);
      takeAw = awvalid && awready;
      takeW = wvalid && wready;
      @(posedge ref_clk);
      if (takeAw) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (takeW) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(negedge ref_clk); while (!bvalid);
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [33:0] e,
                    input logic [33:0] m);
    @(posedge ref_clk);
    notes.push_back('{nm, e, m});
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge ref_clk); while (!arready);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    do @(negedge ref_clk); while (!rvalid);
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask : rd
  task automatic probe(input string nm, input logic [33:0] e, input logic [33:0] m);
    @(posedge ref_clk);
    notes.push_back('{nm, e, m});
    probeReq <= 1'b1;
    @(posedge ref_clk);
    probeReq <= 1'b0;
  endtask : probe
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] m;
    logic [15:0] fixedMix [4];
    fixedMix = '{16'h4000, 16'h4001, 16'h0FFF, 16'h1000};
    {ref_clk, reset_n, run, extra, awvalid, wvalid, bready, arvalid, rready, probeReq} = '0;
    {awaddr, araddr, wdata, mixtureIn} = '0;
    {miscompares, cmpCount, cycles} = '0;
    sparkOn = 1'b1;
    void'($urandom(50846));
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd("config", `OFS_CONFIG, {`OKAY, `CFG_RESET}, ALL);
    rd("unmapped", 8'hFC, {`SLVERR, 32'h0}, ALL);
    wr(8'hFC, 32'h1, `SLVERR);
    $display("test registers done");
    extra <= 1'b1;
    wr(`OFS_CONFIG, 32'h00FF_FF00, `OKAY);
    run <= 1'b1;
    repeat (3 * P) @(posedge ref_clk);
    rd("speed interval", `OFS_SPD_INTV, {`OKAY, 32'(P)}, ALL);
    rd("spark interval", `OFS_SPK_INTV, {`OKAY, 32'(D)}, ALL);
    rd("speed", `OFS_SPEED, {`OKAY, SPD}, ALL);
    extra <= 1'b0;
    wr(`OFS_CONFIG, 32'h00FF_FF04, `OKAY);
    repeat (3 * P) @(posedge ref_clk);
    rd("speed from spark", `OFS_SPEED, {`OKAY, SPD}, ALL);
    $display("test speed done");
    wr(`OFS_CONFIG, 32'h0004_0401, `OKAY);
    repeat (3 * P) @(posedge ref_clk);
    rd("falling interval", `OFS_SPK_INTV, {`OKAY, 32'(D - W)}, ALL);
    $display("test polarity done");
    wr(`OFS_CONFIG, 32'h0004_0404, `OKAY);
    wr(`OFS_CRANK, 32'hFFFF_FFF1, `OKAY);
    repeat (3 * P) @(posedge ref_clk);
    rd("angle", `OFS_ANGLE, 34'h0_0000_001E, LOW16);
    probe("angle code", 34'h0_0FFF_0000, 34'h0_0FFF_0000);
    sparkOn <= 1'b0;
    repeat (6 * P) @(posedge ref_clk);
    rd("no spark angle", `OFS_ANGLE, 34'h0_0000_001F, LOW16);
    rd("missing spark", `OFS_STATUS, 34'h4, 34'h4);
    $display("test angle done");
    wr(`OFS_MASK, 32'h1, `OKAY);
    probe("irq", 34'h8, 34'h8);
    run <= 1'b0;
    repeat (2 * P) @(posedge ref_clk);
    wr(`OFS_STATUS, 32'hF, `OKAY);
    rd("status", `OFS_STATUS, 34'h0, 34'h3_0000_0001);
    probe("irq", 34'h0, 34'h8);
    $display("test interrupt done");
    wr(`OFS_ALARM_SEL, 32'h2, `OKAY);
    wr(`OFS_ALARM_HI, 32'h4000, `OKAY);
    wr(`OFS_ALARM_LO, 32'h1000, `OKAY);
    wr(`OFS_OXY_LIMIT, 32'h2000, `OKAY);
    for (int i = 0; i < 10; i++) begin
      m = (i < 4) ? fixedMix[i] : 16'($urandom_range(16'h7FFF));
      mixtureIn <= m;
      repeat (2 * ST + 2) @(posedge ref_clk);
      probe("alarms", {31'h0, m > 16'h4000, m < 16'h1000, m < 16'h2000}, 34'h7);
    end
    $display("test alarms done");
    wr(`OFS_SPD_FULL, 32'h1F3, `SLVERR);
    rd("speed full", `OFS_SPD_FULL, 34'h0_0000_01F4, LOW16);
    wr(`OFS_SPD_ZERO, 32'h300, `SLVERR);
    wr(`OFS_SPK_FULL, 32'hFFFF_FFD7, `SLVERR);
    wr(`OFS_SPK_FULL, 32'hFFFF_FFD8, `OKAY);
    rd("angle full", `OFS_SPK_FULL, 34'h0_0000_FFD8, LOW16);
    $display("test spans done");
    print_verdict();
  end
endmodule : tb_engine_speed_spark_timing
